// File: wru_defines.svh
`ifndef WRU_DEFINES_SVH
`define WRU_DEFINES_SVH

// ==========================================================
// Register indices and byte addresses
`define WRU_CAUSE_IDX 8'h35
`define WRU_CTRL_IDX 8'h36
`define WRU_CAUSE_ADDR {`WRU_CAUSE_IDX, 2'b00}
`define WRU_CTRL_ADDR {`WRU_CTRL_IDX, 2'b00}

// ==========================================================
// Reset cause bit positions
`define WRU_DBG_BIT 4
`define WRU_WDG_BIT 3
`define WRU_BOR_BIT 2
`define WRU_PIN_BIT 1
`define WRU_POR_BIT 0
`define WRU_CAUSE_RESET 8'h01

// ==========================================================
// Control register bit positions
`define WRU_UNLOCK_BIT 4
`define WRU_EN_BIT 3
`define WRU_PSEL_MSB 2

// ==========================================================
// Timing
`define WRU_UNLOCK_CYCLES 3'h4
`define WRU_BASE_TICKS 22'h004000
`define WRU_OSC_FREQ_MHZ 1
`define WRU_CLK_PERIOD_NS 50
`define WRU_BG_STARTUP_NS 70000
`define WRU_BG_CYCLES ((`WRU_BG_STARTUP_NS + `WRU_CLK_PERIOD_NS - 1) / `WRU_CLK_PERIOD_NS)
`define WRU_STARTUP_CYCLES 16

`endif

// File: wru_pkg.sv
package wru_pkg;

   // ==========================================================
   // Control register layout
   typedef struct packed {
      logic [2:0] rsvd;
      logic wdogChangeUnlock;
      logic wdogEnableBit;
      logic [2:0] wdogPrescaleSel;
   } wru_ctrl_t;

   // ==========================================================
   // Reset cause layout
   typedef struct packed {
      logic [2:0] rsvd;
      logic debugResetFlag;
      logic wdogResetFlag;
      logic brownoutResetFlag;
      logic pinResetFlag;
      logic poweronResetFlag;
   } wru_cause_t;

endpackage : wru_pkg

// File: wru_watchdog_reset_unit.sv
`timescale 1ns/1ps
`include "wru_defines.svh"

module wru_watchdog_reset_unit
   import wru_pkg::*;
#(
   parameter logic [21:0] BASE_TICKS = `WRU_BASE_TICKS,
   parameter int STARTUP_CYCLES = `WRU_STARTUP_CYCLES
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Avalon-MM slave
   input wire logic [9:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Fuses
   input wire logic wdogAlwaysOnFuse,
   input wire logic [2:0] brownoutLevelFuse,
   // Asynchronous sources
   input wire logic wdogOscClk,
   input wire logic pinResetReq,
   input wire logic brownoutResetReq,
   input wire logic debugResetReq,
   // Same-clock inputs
   input wire logic wdogRestart,
   input wire logic comparatorBandgapSel,
   input wire logic converterEnable,
   // Outputs
   output logic wdogResetPulse,
   output logic startupHold,
   output logic bandgapOn,
   output logic bandgapReady
);

   // ==========================================================
   // Local constants
   localparam logic [10:0] BG_CYCLES = 11'(`WRU_BG_CYCLES);
   localparam logic [7:0] HOLD_LOAD = 8'(STARTUP_CYCLES);

   // ==========================================================
   // Declarations
   logic [3:0] asyncIn; // Raw pins
   logic [3:0] sync1_q; // First stage only
   logic [3:0] sync2_q; // Stable copies
   logic oscPrev_q; // Oscillator edge history
   logic oscTick; // One tick per oscillator period
   logic pinSync;
   logic borSync;
   logic dbgSync;
   logic ack_q; // Bus answer cycle
   logic [31:0] readdata_q;
   logic wrStrobe;
   logic wrCtrl;
   logic wrCause;
   wru_ctrl_t wd; // Write data as control
   logic startSeq;
   logic fuseTaken_q;
   logic level2_q; // Safety level two
   logic enable_q;
   logic [2:0] psel_q;
   logic [2:0] unlockCnt_q; // Change window
   logic enEff;
   logic [21:0] count_q;
   logic pulse_q;
   logic pulseDly_q;
   logic chipReset;
   logic [7:0] holdCnt_q;
   logic hold_q;
   logic [7:0] flags_q;
   logic [7:0] setMask;
   logic [7:0] clrMask;
   logic bgReq;
   logic bgOn_q;
   logic [10:0] bgCnt_q;
   logic bgReady_q;

   // ==========================================================
   // Functions
   // Register hit test
   function automatic logic isReg(input logic [9:0] a, input logic [9:0] r);
      return a == r;
   endfunction : isReg

   // Expiry length for a prescale code
   function automatic logic [21:0] expiryLimit(input logic [2:0] sel);
      return BASE_TICKS << sel;
   endfunction : expiryLimit

   // ==========================================================
   // Input synchronisers
   assign asyncIn = {debugResetReq, brownoutResetReq, pinResetReq, wdogOscClk};

   // Two flops per pin, first read only by second
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_sync
         always_ff @(posedge clk)
         begin
            if (!resetn)
            begin
               sync1_q[gi] <= 1'b0;
               sync2_q[gi] <= 1'b0;
            end
            else
            begin
               sync1_q[gi] <= asyncIn[gi];
               sync2_q[gi] <= sync1_q[gi];
            end
         end
      end
   endgenerate

   assign pinSync = sync2_q[1];
   assign borSync = sync2_q[2];
   assign dbgSync = sync2_q[3];

   // Oscillator edge detect on the stable copy
   always_ff @(posedge clk)
   begin
      if (!resetn)
         oscPrev_q <= 1'b0;
      else
         oscPrev_q <= sync2_q[0];
   end

   assign oscTick = sync2_q[0] && !oscPrev_q;

   // ==========================================================
   // Avalon-MM slave: one wait cycle per access
   assign waitrequest = (read || write) && !ack_q;
   assign readdata = readdata_q;
   assign wrStrobe = write && ack_q && byteenable[0];
   assign wrCtrl = wrStrobe && isReg(address, `WRU_CTRL_ADDR);
   assign wrCause = wrStrobe && isReg(address, `WRU_CAUSE_ADDR);
   assign wd = writedata[7:0];
   assign startSeq = wd.wdogChangeUnlock && wd.wdogEnableBit;

   // Answer strobe
   always_ff @(posedge clk)
   begin
      if (!resetn)
         ack_q <= 1'b0;
      else
         ack_q <= (read || write) && !ack_q;
   end

   // Read data captured as the answer begins
   always_ff @(posedge clk)
   begin
      if (!resetn)
         readdata_q <= 32'h0;
      else if (read && !ack_q)
      begin
         if (isReg(address, `WRU_CAUSE_ADDR))
            readdata_q <= {24'h0, 3'h0, flags_q[4:0]};
         else if (isReg(address, `WRU_CTRL_ADDR))
            readdata_q <= {24'h0, 3'h0, unlockCnt_q != 3'h0, enEff, psel_q};
         else
            // Unmapped reads as zero
            readdata_q <= 32'h0;
      end
   end

   // ==========================================================
   // Safety level from the fuse
   // fuse caught after reset release
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         fuseTaken_q <= 1'b0;
         level2_q <= 1'b0;
      end
      else if (!fuseTaken_q)
      begin
         fuseTaken_q <= 1'b1;
         level2_q <= wdogAlwaysOnFuse;
      end
   end

   assign enEff = enable_q || level2_q;

   // ==========================================================
   // Control register and change window
   // Level two ignores the stored enable, so a disable write has no effect
   always_ff @(posedge clk)
   begin
      if (!resetn || chipReset)
      begin
         enable_q <= 1'b0;
         psel_q <= 3'h0;
         unlockCnt_q <= 3'h0;
      end
      else if (wrCtrl && startSeq)
         unlockCnt_q <= `WRU_UNLOCK_CYCLES;
      else if (wrCtrl && unlockCnt_q != 3'h0 && !wd.wdogChangeUnlock)
      begin
         enable_q <= wd.wdogEnableBit;
         psel_q <= wd.wdogPrescaleSel;
         unlockCnt_q <= 3'h0;
      end
      else
      begin
         if (wrCtrl && wd.wdogEnableBit)
            enable_q <= 1'b1;
         if (unlockCnt_q != 3'h0)
            unlockCnt_q <= unlockCnt_q - 3'h1;
      end
   end

   // ==========================================================
   // Watchdog counter
   // clear on restart, disable, reset
   always_ff @(posedge clk)
   begin
      if (!resetn || chipReset || wdogRestart || !enEff)
      begin
         count_q <= 22'h0;
         pulse_q <= 1'b0;
      end
      else if (oscTick)
      begin
         if (count_q >= expiryLimit(psel_q) - 22'h1)
         begin
            count_q <= 22'h0;
            pulse_q <= 1'b1;
         end
         else
         begin
            count_q <= count_q + 22'h1;
            pulse_q <= 1'b0;
         end
      end
      else
         pulse_q <= 1'b0;
   end

   assign wdogResetPulse = pulse_q;
   assign chipReset = pulse_q || pinSync || borSync || dbgSync;

   // ==========================================================
   // Start-up delay after the watchdog pulse
   always_ff @(posedge clk)
   begin
      if (!resetn)
         pulseDly_q <= 1'b0;
      else
         pulseDly_q <= pulse_q;
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         holdCnt_q <= 8'h0;
         hold_q <= 1'b0;
      end
      else if (pulseDly_q && !pulse_q)
      begin
         holdCnt_q <= HOLD_LOAD;
         hold_q <= 1'b1;
      end
      else if (holdCnt_q != 8'h0)
      begin
         holdCnt_q <= holdCnt_q - 8'h1;
         hold_q <= holdCnt_q != 8'h1;
      end
      else
         hold_q <= 1'b0;
   end

   assign startupHold = hold_q;

   // ==========================================================
   // Reset cause flags; a set wins over a clear in the same cycle
   assign setMask = {3'h0, dbgSync, pulse_q, borSync, pinSync, 1'b0};
   assign clrMask = wrCause ? {3'h7, ~writedata[4:0]} : 8'h0;

   always_ff @(posedge clk)
   begin
      if (!resetn)
         flags_q <= `WRU_CAUSE_RESET;
      else
         flags_q <= (flags_q & ~clrMask) | setMask;
   end

   // ==========================================================
   // Bandgap reference enable and start-up timer
   // any of three requests
   assign bgReq = (brownoutLevelFuse != 3'h7) || comparatorBandgapSel || converterEnable;

   always_ff @(posedge clk)
   begin
      if (!resetn)
         bgOn_q <= 1'b0;
      else
         bgOn_q <= bgReq;
   end

   // Ready flag helps software honour the start-up wait
   // start-up wait counted
   always_ff @(posedge clk)
   begin
      if (!resetn || !bgOn_q)
      begin
         bgCnt_q <= 11'h0;
         bgReady_q <= 1'b0;
      end
      else if (bgCnt_q < BG_CYCLES)
         bgCnt_q <= bgCnt_q + 11'h1;
      else
         bgReady_q <= 1'b1;
   end

   assign bandgapOn = bgOn_q;
   assign bandgapReady = bgReady_q;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   property p_pulse_one;
      pulse_q |=> !pulse_q;
   endproperty
   a_pulse_one: assert property (p_pulse_one) else $error("pulse too long");

   property p_hold_start;
      $fell(pulse_q) |=> hold_q ##STARTUP_CYCLES !hold_q;
   endproperty
   a_hold_start: assert property (p_hold_start) else $error("start-up delay wrong");

   property p_tick_cause;
      $rose(pulse_q) |-> $past(oscTick);
   endproperty
   a_tick_cause: assert property (p_tick_cause) else $error("pulse without tick");

   property p_restart_clr;
      wdogRestart |=> count_q == 22'h0 && !pulse_q;
   endproperty
   a_restart_clr: assert property (p_restart_clr) else $error("restart kept count");

   property p_window_len;
      wrCtrl && startSeq && !chipReset |=> unlockCnt_q == 3'h4;
   endproperty
   a_window_len: assert property (p_window_len) else $error("window not four");

   property p_psel_locked;
      $changed(psel_q) |-> $past(unlockCnt_q) != 3'h0 || $past(chipReset);
   endproperty
   a_psel_locked: assert property (p_psel_locked) else $error("prescale changed locked");

   property p_level2_reads;
      read && ack_q && level2_q && isReg(address, `WRU_CTRL_ADDR) |-> readdata[3];
   endproperty
   a_level2_reads: assert property (p_level2_reads) else $error("enable read zero");

   property p_rsvd_zero;
      read && ack_q |-> readdata[31:5] == 27'h0;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set");

   property p_wdg_flag;
      pulse_q |=> flags_q[`WRU_WDG_BIT];
   endproperty
   a_wdg_flag: assert property (p_wdg_flag) else $error("watchdog flag missed");

   property p_bandgap;
      bgOn_q == $past(bgReq) || !$past(resetn);
   endproperty
   a_bandgap: assert property (p_bandgap) else $error("bandgap wrong");

   c_expiry: cover property (pulse_q);
   c_change: cover property (wrCtrl && unlockCnt_q != 3'h0 && !wd.wdogChangeUnlock);
   c_lapse: cover property (unlockCnt_q == 3'h1 && !wrCtrl);

endmodule : wru_watchdog_reset_unit

// File: wru_watchdog_reset_unit_test.sv
`timescale 1ns/1ps
`include "wru_defines.svh"

module wru_watchdog_reset_unit_test
   import wru_pkg::*;
;
   // ==========================================================
   // Settings
   localparam int TICK_CYC = 20; // Oscillator period in clk cycles
   localparam int HOLD = 4; // Shortened start-up stretch
   localparam int LIMIT = 30000; // Cycle ceiling for the run
   localparam logic [9:0] CAUSE = `WRU_CAUSE_ADDR;
   localparam logic [9:0] CTRL = `WRU_CTRL_ADDR;

   // ==========================================================
   // Bench signals
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [9:0] address = 10'h000;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h00000000;
   logic [31:0] readdata;
   logic waitrequest;
   logic wdogAlwaysOnFuse = 1'b0;
   logic [2:0] brownoutLevelFuse = 3'h7; // Detector off
   logic wdogOscClk = 1'b0;
   logic [2:0] srcReq = 3'h0; // Debug, brown-out, pin
   logic wdogRestart = 1'b0;
   logic comparatorBandgapSel = 1'b0;
   logic converterEnable = 1'b0;
   logic wdogResetPulse, startupHold, bandgapOn, bandgapReady;
   int err_count = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [4:0] oscDiv = 5'h00;

   // ==========================================================
   // Device under test, counts shortened
   wru_watchdog_reset_unit #(.BASE_TICKS(22'h000010), .STARTUP_CYCLES(HOLD))
   u_wru_watchdog_reset_unit
   (
      .clk(clk), .resetn(resetn), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(4'h1), .readdata(readdata),
      .waitrequest(waitrequest), .wdogAlwaysOnFuse(wdogAlwaysOnFuse),
      .brownoutLevelFuse(brownoutLevelFuse), .wdogOscClk(wdogOscClk),
      .pinResetReq(srcReq[0]), .brownoutResetReq(srcReq[1]),
      .debugResetReq(srcReq[2]), .wdogRestart(wdogRestart),
      .comparatorBandgapSel(comparatorBandgapSel), .converterEnable(converterEnable),
      .wdogResetPulse(wdogResetPulse), .startupHold(startupHold),
      .bandgapOn(bandgapOn), .bandgapReady(bandgapReady)
   );

   // ==========================================================
   // Clock, oscillator and timeout
   always #25 clk = ~clk;

   // Oscillator at 1 MHz, derived so it stays reproducible
   always @(posedge clk)
   begin
      oscDiv <= (oscDiv == 5'h09) ? 5'h00 : oscDiv + 5'h01;
      if (oscDiv == 5'h09)
         wdogOscClk <= ~wdogOscClk;
   end

   // Hang guard
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         err_count++;
         $display("ERROR at %0t: timeout", $time);
         end_sim();
      end
   end

   // ==========================================================
   // Shared tasks
   task automatic end_sim();
      $display("checks_done=%0d err_count=%0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e)
         $display("ERROR at %0t: got %h expected %h", $time, g, e);
      if (g !== e)
         err_count++;
   endtask : chk

   // One Avalon access; held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d,
                      output logic [31:0] q);
      @(posedge clk);
      address <= a;
      writedata <= {24'h000000, d};
      write <= wr;
      read <= ~wr;
      // Sample the answer at rising edges only; release at that same edge
      @(posedge clk);
      while (waitrequest !== 1'b0)
         @(posedge clk);
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask : bus

   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rc(input logic [9:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(q, e);
   endtask : rc

   // Reset with a given fuse; fuse settles before first access
   task automatic do_reset(input logic fuse);
      @(posedge clk);
      resetn <= 1'b0;
      wdogAlwaysOnFuse <= fuse;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      repeat (2) @(posedge clk);
   endtask : do_reset

   // ==========================================================
   // Scenarios
   task automatic t_regs();
      rc(CAUSE, 32'h01);
      rc(CTRL, 32'h00);
      rc(10'h3fc, 32'h00);
      wr(CTRL, 8'he8);
      rc(CTRL, 32'h08);
      wr(CTRL, 8'h00);
      wr(CTRL, 8'h0b);
      rc(CTRL, 32'h08);
      wr(CTRL, 8'h18);
      rc(CTRL, 32'h18);
      repeat (6) @(posedge clk);
      rc(CTRL, 32'h08);
      wr(CTRL, 8'h03);
      rc(CTRL, 32'h08);
      wr(CTRL, 8'h18);
      wr(CTRL, 8'h05);
      rc(CTRL, 32'h05);
      $display("register test done");
   endtask : t_regs

   // Each source sets its own flag; power-on flag survives
   task automatic t_flags();
      logic [7:0] exp [3] = '{8'h03, 8'h04, 8'h10};
      for (int i = 0; i < 3; i++)
      begin
         wr(CTRL, 8'h08);
         srcReq <= 3'h1 << i;
         repeat (4) @(posedge clk);
         srcReq <= 3'h0;
         repeat (6) @(posedge clk);
         rc(CTRL, 32'h00);
         rc(CAUSE, {24'h0, exp[i]});
         wr(CAUSE, 8'h00);
         rc(CAUSE, 32'h00);
      end
      $display("flag test done");
   endtask : t_flags

   // Expiry timing for one code, then the reset it raises
   task automatic t_expire(input logic [2:0] p);
      int n = 0;
      int h = 0;
      int t = 16 << p;
      wr(CTRL, 8'h18);
      wr(CTRL, {5'h01, p});
      @(negedge clk);
      while (wdogResetPulse !== 1'b1 && n < 3000)
      begin
         n++;
         @(negedge clk);
      end
      chk({31'h0, n >= (t - 1) * TICK_CYC && n <= t * TICK_CYC + 8}, 32'h1);
      chk({31'h0, startupHold}, 32'h0);
      @(negedge clk);
      chk({31'h0, wdogResetPulse}, 32'h0);
      repeat (12)
      begin
         h += (startupHold === 1'b1);
         @(negedge clk);
      end
      chk(h, HOLD);
      rc(CAUSE, 32'h08);
      rc(CTRL, 32'h00);
      wr(CAUSE, 8'h00);
      $display("expiry test done");
   endtask : t_expire

   // Restart holds the count off; disabling stops it
   task automatic t_restart();
      int seen = 0;
      wr(CTRL, 8'h08);
      repeat (20)
      begin
         repeat (100)
         begin
            @(negedge clk);
            seen += (wdogResetPulse === 1'b1);
         end
         @(posedge clk);
         wdogRestart <= 1'b1;
         @(posedge clk);
         wdogRestart <= 1'b0;
      end
      wr(CTRL, 8'h18);
      wr(CTRL, 8'h00);
      rc(CTRL, 32'h00);
      repeat (500)
      begin
         @(negedge clk);
         seen += (wdogResetPulse === 1'b1);
      end
      chk(seen, 0);
      $display("restart test done");
   endtask : t_restart

   // Reference follows any of its three requests
   task automatic t_bandgap();
      logic [5:0] tab [4] = '{6'b111000, 6'b110001, 6'b111101, 6'b111011};
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk);
         {brownoutLevelFuse, comparatorBandgapSel, converterEnable} <= tab[i][5:1];
         repeat (3) @(posedge clk);
         @(negedge clk);
         chk({31'h0, bandgapOn}, {31'h0, tab[i][0]});
      end
      @(posedge clk);
      {brownoutLevelFuse, comparatorBandgapSel, converterEnable} <= 5'b11100;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk({31'h0, bandgapReady}, 32'h0);
      // Converter alone; ready must wait out the start-up time
      @(posedge clk);
      converterEnable <= 1'b1;
      repeat (`WRU_BG_CYCLES - 8) @(posedge clk);
      @(negedge clk);
      chk({31'h0, bandgapReady}, 32'h0);
      repeat (16) @(posedge clk);
      @(negedge clk);
      chk({31'h0, bandgapReady}, 32'h1);
      @(posedge clk);
      converterEnable <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk({31'h0, bandgapReady}, 32'h0);
      $display("bandgap test done");
   endtask : t_bandgap

   // Level two: always enabled, period still changeable
   task automatic t_level2();
      do_reset(1'b1);
      rc(CTRL, 32'h08);
      wr(CTRL, 8'h18);
      wr(CTRL, 8'h00);
      rc(CTRL, 32'h08);
      wr(CTRL, 8'h18);
      wr(CTRL, 8'h02);
      rc(CTRL, 32'h0a);
      $display("level two test done");
   endtask : t_level2

   // ==========================================================
   // Main sequence
   initial
   begin
      do_reset(1'b0);
      t_regs();
      t_flags();
      for (int p = 0; p < 3; p++)
         t_expire(p[2:0]);
      t_restart();
      t_bandgap();
      t_level2();
      end_sim();
   end

endmodule : wru_watchdog_reset_unit_test
